// *** logic/pls_loader.sv ***
// synthesizer configuration loader: sequencer, byte table and register port
// assumes a 25 MHz i_clk, a free-running link clock and an async select pin
//
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/100ps
// What this block does
// (R1) Marker goes low at sequence start, high only after all streams sent.
// (R2) Before halting, marker held low about one second to light a lamp.
// (R3) Load strobe goes low before the first byte of every stream.
// (R4) Strobe rises after the stream's last byte, then next stream is decided.
// (R5) Stream count is configurable, default two; a counter tracks streams sent.
// (R6) Bytes per stream configurable, default three; a separate counter tracks them.
// (R7) Payload of 22 bits is padded with leading zeros to the stream length, 24 bits with the default three bytes.
// (R8) The synthesizer keeps only the last bits before the strobe rises.
// (R9) Bytes come from a table through one pointer running across streams.
// (R10) After a load the select pin is sampled: high halts, low repeats.
// (R11) Diagnostic mode repeats the whole load, framing included, for as long as the select pin stays low.
// (R12) Otherwise the block halts for good after the last stream.
// (R13) Each byte goes out bit by bit with exactly eight clock pulses.
// (R14) Strobe stays low across all bytes of one stream.
// (R15) All synthesizer pins keep their last levels while halted.
// (R16) Bits leave most significant first, so padding precedes payload.
module pls_loader import pls_pkg::*; #(
  parameter int unsigned P_STREAMS = STREAMS_DEF,
  parameter int unsigned P_BYTES = BYTES_DEF,
  parameter int unsigned P_PAYLOAD = PAYLOAD_BITS,
  parameter int unsigned P_LAMP_HOLD_CYC = LAMP_HOLD_CYC
) (
  // system clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // link clock
  input wire logic i_link_clk,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // diagnostic select pin, pulled high outside
  input wire logic i_diagnostic_select,
  // synthesizer pins
  output logic o_sclk,
  output logic o_sdata,
  output logic o_load_strobe,
  output logic o_marker
);
  localparam int unsigned PW = $clog2(TABLE_DEPTH);
  localparam int unsigned LW = $clog2(P_LAMP_HOLD_CYC + 1);
  localparam logic [LW-1:0] LAMP_LAST = LW'(P_LAMP_HOLD_CYC - 1);

  // ==========================================================
  // state and storage
  pls_state_t state_q, state_d;
  logic run_q;
  logic [CNT_W-1:0] streams_q, bytes_q;
  logic [CNT_W-1:0] str_cnt_q, byte_cnt_q;
  logic [PW-1:0] tidx_q, ptr_q;
  logic [7:0] tbl_q [TABLE_DEPTH];
  logic [7:0] txb_q;
  logic req_q, marker_q, strobe_q;
  logic [LW-1:0] lamp_q;
  logic ak1_q, ak2_q, ak3_q, dg1_q, dg2_q;
  logic [31:0] rdata_q;
  logic ack_tgl;
  pls_wire_t pins;

  // ==========================================================
  // synchronisers: ack toggle from link domain, select pin
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      ak1_q <= 1'b0;
      ak2_q <= 1'b0;
      ak3_q <= 1'b0;
      dg1_q <= 1'b1;
      dg2_q <= 1'b1;
    end else begin
      ak1_q <= ack_tgl;
      ak2_q <= ak1_q;
      ak3_q <= ak2_q;
      dg1_q <= i_diagnostic_select;
      dg2_q <= dg1_q;
    end
  end
  wire ack_evt = ak2_q ^ ak3_q;

  // ==========================================================
  // register decode
  wire wr_ctrl = i_wr && (i_addr == ADDR_CTRL);
  wire wr_streams = i_wr && (i_addr == ADDR_STREAMS);
  wire wr_bytes = i_wr && (i_addr == ADDR_BYTES);
  wire wr_tidx = i_wr && (i_addr == ADDR_TIDX);
  wire wr_tdata = i_wr && (i_addr == ADDR_TDATA);
  wire halted = (state_q == S_HALT);
  wire [31:0] status_w = (32'(state_q) << ST_STATE_LSB)
    | (32'(str_cnt_q) << ST_STREAM_LSB)
    | (32'(byte_cnt_q) << ST_BYTE_LSB)
    | (32'(ptr_q) << ST_PTR_LSB)
    | (32'(dg2_q) << ST_DIAG_BIT)
    | (32'(halted) << ST_HALT_BIT);
  // unmapped addresses read zero
  wire [31:0] rd_mux =
    (i_addr == ADDR_CTRL) ? 32'(run_q) << CTRL_RUN_BIT :
    (i_addr == ADDR_STREAMS) ? 32'(streams_q) :
    (i_addr == ADDR_BYTES) ? 32'(bytes_q) :
    (i_addr == ADDR_TIDX) ? 32'(tidx_q) :
    (i_addr == ADDR_TDATA) ? 32'(tbl_q[tidx_q]) :
    (i_addr == ADDR_STATUS) ? status_w : 32'h0000_0000;

  // configuration registers; counts may be rewritten any time but
  // only a change made while idle gives a clean sequence
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      run_q <= CTRL_RUN_RST;
      streams_q <= CNT_W'(P_STREAMS); // R5
      bytes_q <= CNT_W'(P_BYTES); // R6
      tidx_q <= '0;
    end else begin
      if (wr_ctrl) run_q <= i_wdata[CTRL_RUN_BIT];
      if (wr_streams) streams_q <= i_wdata[CNT_W-1:0];
      if (wr_bytes) bytes_q <= i_wdata[CNT_W-1:0];
      if (wr_tidx) tidx_q <= i_wdata[PW-1:0];
      else if (wr_tdata) tidx_q <= tidx_q + PW'(1);
    end
  end
  // byte table: no reset, software fills it before setting run
  always_ff @(posedge i_clk) begin
    if (wr_tdata) tbl_q[tidx_q] <= i_wdata[7:0];
  end
  // read data stands only in the cycle after the strobe
  always_ff @(posedge i_clk) begin
    if (!i_resetn) rdata_q <= 32'h0000_0000;
    else if (i_rd) rdata_q <= rd_mux;
    else rdata_q <= 32'h0000_0000;
  end

  // ==========================================================
  // leading-zero padding of the fetched byte
  wire [7:0] pad_w = {1'b0, bytes_q, 3'b000} - 8'(P_PAYLOAD);
  wire pad_none = ({1'b0, bytes_q, 3'b000} <= 8'(P_PAYLOAD)); // short streams carry no padding
  wire [7:0] lo_w = {1'b0, byte_cnt_q, 3'b000};
  wire [7:0] hi_w = lo_w + 8'(BITS_PER_BYTE);
  wire [7:0] pad_lo = pad_w - lo_w;
  wire [7:0] pad_mask =
    pad_none ? 8'hff :
    (pad_w >= hi_w) ? 8'h00 :
    (pad_w > lo_w) ? (8'hff >> pad_lo[2:0]) : 8'hff; // R7
  wire [7:0] fetch_w = tbl_q[ptr_q] & pad_mask; // R9
  wire byte_last = (byte_cnt_q + CNT_W'(1)) == bytes_q;
  wire stream_last = (str_cnt_q + CNT_W'(1)) == streams_q;
  wire lamp_end = (lamp_q == LAMP_LAST);

  // ==========================================================
  // sequencer next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      S_IDLE: begin
        if (run_q) state_d = S_START;
      end
      S_START: begin
        state_d = (streams_q == '0) ? S_DONE : S_STRM;
      end
      S_STRM: begin
        state_d = (bytes_q == '0) ? S_ENDS : S_SEND;
      end
      S_SEND: begin
        state_d = S_WAIT;
      end
      S_WAIT: begin
        if (ack_evt) state_d = byte_last ? S_ENDS : S_SEND; // R14
      end
      S_ENDS: begin
        state_d = stream_last ? S_DONE : S_STRM; // R4 R5
      end
      S_DONE: begin
        state_d = dg2_q ? S_LAMP : S_START; // R10 R11
      end
      S_LAMP: begin
        if (lamp_end) state_d = S_HALT;
      end
      S_HALT: begin
        state_d = S_HALT; // R12 R15
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end
  always_ff @(posedge i_clk) begin
    if (!i_resetn) state_q <= S_IDLE;
    else state_q <= state_d;
  end

  // stream, byte and table pointer counters
  always_ff @(posedge i_clk) begin
    if (!i_resetn || state_q == S_START) begin
      str_cnt_q <= '0;
      ptr_q <= '0;
      byte_cnt_q <= '0;
    end else if (state_q == S_STRM) begin
      byte_cnt_q <= '0; // R6
    end else if (state_q == S_WAIT && ack_evt) begin
      byte_cnt_q <= byte_cnt_q + CNT_W'(1); // R6
      ptr_q <= ptr_q + PW'(1); // R9
    end else if (state_q == S_ENDS) begin
      str_cnt_q <= str_cnt_q + CNT_W'(1); // R5
    end
  end

  // byte hand-off to the link domain: byte held until the ack toggle
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      req_q <= 1'b0;
      txb_q <= 8'h00;
    end else if (state_q == S_SEND) begin
      req_q <= ~req_q;
      txb_q <= fetch_w;
    end
  end

  // strobe framing; the strobe leaves one cycle ahead of the request so
  // it is low well before the first link-side clock pulse
  always_ff @(posedge i_clk) begin
    if (!i_resetn) strobe_q <= 1'b1;
    else if (state_q == S_STRM) strobe_q <= 1'b0; // R3
    else if (state_q == S_ENDS) strobe_q <= 1'b1; // R4
  end

  // marker: low over the load, high once per pass, low again for the lamp
  always_ff @(posedge i_clk) begin
    if (!i_resetn) marker_q <= 1'b1;
    else if (state_q == S_START) marker_q <= 1'b0; // R1 R11
    else if (state_q == S_DONE) marker_q <= 1'b1; // R1
    else if (state_q == S_LAMP) marker_q <= lamp_end; // R2
  end
  always_ff @(posedge i_clk) begin
    if (!i_resetn || state_q != S_LAMP) lamp_q <= '0;
    else if (!lamp_end) lamp_q <= lamp_q + LW'(1); // R2
  end

  // ==========================================================
  // link-domain shifter
  pls_shifter u_shifter (
    .i_link_clk(i_link_clk),
    .i_resetn(i_resetn),
    .i_req_tgl(req_q),
    .i_byte(txb_q),
    .o_ack_tgl(ack_tgl),
    .o_pins(pins)
  );

  assign o_sclk = pins.sclk;
  assign o_sdata = pins.sdata;
  assign o_load_strobe = strobe_q;
  assign o_marker = marker_q;
  assign o_rdata = rdata_q;

  // ==========================================================
  // checks
  marker_during_load_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R1
    (state_q inside {S_STRM, S_SEND, S_WAIT, S_ENDS}) |-> !marker_q)
    else $error("marker high while streams are going out");
  marker_rise_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R1
    $rose(marker_q) |-> $past(state_q) inside {S_DONE, S_LAMP})
    else $error("marker rose before the load was complete");
  lamp_low_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R2
    (state_q == S_LAMP && $past(state_q) == S_LAMP) |-> !marker_q)
    else $error("lamp not lit during the hold");
  lamp_length_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R2
    (state_q == S_HALT && $past(state_q) == S_LAMP) |-> $past(lamp_q) == LAMP_LAST)
    else $error("lamp hold length wrong");
  strobe_before_byte_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R3
    (state_q == S_SEND) |-> !strobe_q)
    else $error("byte requested with strobe high");
  strobe_held_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R14
    (state_q == S_WAIT && ack_evt && !byte_last) |=> !strobe_q ##1 !strobe_q)
    else $error("strobe pulsed between bytes");
  strobe_rise_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R4
    (state_q == S_WAIT && ack_evt && byte_last) |=> ##1 strobe_q)
    else $error("strobe not raised after the last byte");
  stream_count_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R5
    (state_q == S_DONE && $past(state_q) == S_ENDS) |-> str_cnt_q == streams_q)
    else $error("wrong number of streams sent");
  pointer_step_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R9
    (state_q == S_WAIT && ack_evt) |=> ptr_q == $past(ptr_q) + PW'(1))
    else $error("table pointer did not advance");
  padding_zero_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R7
    (state_q == S_SEND && byte_cnt_q == '0 && pad_w < 8'h08)
      |=> (txb_q >> (8'h08 - pad_w)) == 8'h00)
    else $error("padding bits not zero");
  diag_repeat_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R10 R11
    (state_q == S_DONE && !dg2_q) |=> state_q == S_START ##1 !marker_q)
    else $error("diagnostic pass did not restart");
  halt_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R12 R15
    (state_q == S_HALT) |=> state_q == S_HALT && $stable(marker_q)
      && $stable(strobe_q) && $stable(req_q))
    else $error("outputs moved while halted");
  marker_done_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R1
    (state_q == S_DONE) |=> marker_q)
    else $error("marker not raised after the last stream");
  byte_count_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R6
    (state_q == S_ENDS && $past(state_q) == S_WAIT) |-> byte_cnt_q == bytes_q)
    else $error("wrong number of bytes in the stream");
endmodule

// *** logic/pls_pkg.sv ***
// shared constants, state codes and carrier types of the synthesizer loader
// assumes a 25 MHz system clock and a register port with byte addresses
package pls_pkg;
  // ==========================================================
  // timing
  localparam int unsigned CLK_FREQ_HZ = 25_000_000;
  localparam int unsigned LAMP_HOLD_MS = 1000;
  localparam int unsigned LAMP_HOLD_CYC = LAMP_HOLD_MS * (CLK_FREQ_HZ / 1000);
  // ==========================================================
  // sequence defaults
  localparam int unsigned STREAMS_DEF = 2;
  localparam int unsigned BYTES_DEF = 3;
  localparam int unsigned PAYLOAD_BITS = 22;
  localparam int unsigned TABLE_DEPTH = 16;
  localparam int unsigned CNT_W = 4;
  localparam int unsigned BITS_PER_BYTE = 8;
  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STREAMS = 8'h04;
  localparam logic [7:0] ADDR_BYTES = 8'h08;
  localparam logic [7:0] ADDR_TIDX = 8'h0c;
  localparam logic [7:0] ADDR_TDATA = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  // ==========================================================
  // field positions and reset values
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam logic CTRL_RUN_RST = 1'b0;
  localparam int unsigned ST_STATE_LSB = 0;
  localparam int unsigned ST_STREAM_LSB = 4;
  localparam int unsigned ST_BYTE_LSB = 8;
  localparam int unsigned ST_PTR_LSB = 12;
  localparam int unsigned ST_DIAG_BIT = 16;
  localparam int unsigned ST_HALT_BIT = 17;
  // ==========================================================
  // sequencer states
  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_START = 4'h1,
    S_STRM = 4'h2,
    S_SEND = 4'h3,
    S_WAIT = 4'h4,
    S_ENDS = 4'h5,
    S_DONE = 4'h6,
    S_LAMP = 4'h7,
    S_HALT = 4'h8
  } pls_state_t;
  // serial clock and data leaving the link domain together
  typedef struct packed {
    logic sclk;
    logic sdata;
  } pls_wire_t;
endpackage

// *** logic/pls_shifter.sv ***
// link-domain byte shifter: eight serial clock pulses per byte, msb first
// assumes i_byte is held stable from a request toggle until the ack toggle
`timescale 1ns/100ps
module pls_shifter import pls_pkg::*; (
  // link clock and system reset (synchronised here)
  input wire logic i_link_clk,
  input wire logic i_resetn,
  // byte hand-off from the system domain
  input wire logic i_req_tgl,
  input wire logic [7:0] i_byte,
  output logic o_ack_tgl,
  // serial pins
  output pls_wire_t o_pins
);
  // ==========================================================
  // reset and request synchronisers
  logic rs1_q, rs2_q, rq1_q, rq2_q, rq3_q;
  logic busy_q, phase_q, ack_q;
  logic [2:0] bit_q;
  logic [7:0] sh_q;
  pls_wire_t pins_q;
  wire link_rst_n = rs2_q;
  wire req_evt = rq2_q ^ rq3_q;
  wire last_bit = (bit_q == 3'h7);
  always_ff @(posedge i_link_clk) begin
    rs1_q <= i_resetn;
    rs2_q <= rs1_q;
  end
  always_ff @(posedge i_link_clk) begin
    if (!link_rst_n) begin
      rq1_q <= 1'b0;
      rq2_q <= 1'b0;
      rq3_q <= 1'b0;
    end else begin
      rq1_q <= i_req_tgl;
      rq2_q <= rq1_q;
      rq3_q <= rq2_q;
    end
  end
  // ==========================================================
  // shift engine: data changes while clock low, stable at rising edge
  always_ff @(posedge i_link_clk) begin
    if (!link_rst_n) begin
      busy_q <= 1'b0;
      phase_q <= 1'b0;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      ack_q <= 1'b0;
      pins_q <= '0;
    end else if (!busy_q) begin
      if (req_evt) begin
        busy_q <= 1'b1;
        phase_q <= 1'b0;
        bit_q <= 3'h0;
        sh_q <= i_byte;
        pins_q.sdata <= i_byte[7]; // R16
      end
    end else if (!phase_q) begin
      pins_q.sclk <= 1'b1; // R13
      phase_q <= 1'b1;
    end else begin
      pins_q.sclk <= 1'b0;
      phase_q <= 1'b0;
      if (last_bit) begin
        busy_q <= 1'b0;
        ack_q <= ~ack_q; // handshake back: byte finished
      end else begin
        bit_q <= bit_q + 3'h1;
        sh_q <= {sh_q[6:0], 1'b0};
        pins_q.sdata <= sh_q[6]; // R16
      end
    end
  end
  assign o_ack_tgl = ack_q;
  assign o_pins = pins_q;
  // ==========================================================
  // checks
  logic [3:0] pulses_q;
  always_ff @(posedge i_link_clk) begin
    if (!link_rst_n || (!busy_q && req_evt)) begin
      pulses_q <= 4'h0;
    end else if (busy_q && !phase_q) begin
      pulses_q <= pulses_q + 4'h1;
    end
  end
  sclk_pulses_a: assert property (@(posedge i_link_clk) disable iff (!link_rst_n) // R13
    $changed(ack_q) |-> pulses_q == 4'h8)
    else $error("byte did not carry eight clock pulses");
  msb_first_a: assert property (@(posedge i_link_clk) disable iff (!link_rst_n) // R16
    ($rose(pins_q.sclk) && bit_q == 3'h0) |-> pins_q.sdata == sh_q[7])
    else $error("first bit out is not the msb");
endmodule

// *** tb/pls_synth_model.sv ***
// listening model of a serially loaded synthesizer: shift register plus latch
// assumes bits are sampled on rising serial clock while the load strobe is low
`timescale 1ns/100ps
module pls_synth_model (
  // serial pins from the loader
  input wire logic i_sclk,
  input wire logic i_sdata,
  input wire logic i_load_strobe
);
  // ==========================================================
  // capture state, read by the bench through hierarchy
  logic [31:0] shreg;
  logic armed;
  int unsigned cnt;
  int unsigned n_stray;
  logic [31:0] words[$];
  int unsigned nbits[$];

  initial begin
    shreg = '0;
    armed = 1'b0;
    cnt = 0;
    n_stray = 0;
  end

  // falling strobe opens a fresh capture
  always @(negedge i_load_strobe) begin
    shreg = '0;
    cnt = 0;
    armed = 1'b1;
  end

  // clocks outside a frame are strays; inside, shift msb first
  always @(posedge i_sclk) begin
    if (i_load_strobe !== 1'b0) begin
      n_stray++;
    end else begin
      shreg = {shreg[30:0], i_sdata};
      cnt++;
    end
  end

  // rising strobe latches; only the final bits would reach the real latch
  always @(posedge i_load_strobe) begin
    if (armed) begin
      words.push_back(shreg);
      nbits.push_back(cnt);
      armed = 1'b0;
    end
  end
endmodule

// *** tb/tb_top.sv ***
// self-checking bench for the synthesizer loader: register tasks and load passes
// assumes the loader's register map and a listening synthesizer model
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin n_errors++; \
  $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module tb_top import pls_pkg::*;;
  localparam int unsigned LAMP = 20;
  localparam int LIMIT = 40000;
  logic i_clk, i_resetn, i_link_clk, i_wr, i_rd, i_diagnostic_select;
  logic [7:0] i_addr;
  logic [31:0] i_wdata, o_rdata, rd_q;
  logic o_sclk, o_sdata, o_load_strobe, o_marker, mk_q;
  logic [7:0] tbl [16];
  logic [3:0] pins;
  int n_errors = 0, compares = 0, cyc = 0, n_r1 = 0, n_fall = 0, low_run = 0, last_low = 0;
  int i, k, base, f0, np;

  pls_loader #(.P_LAMP_HOLD_CYC(LAMP)) dut (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_link_clk(i_link_clk),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_diagnostic_select(i_diagnostic_select),
    .o_sclk(o_sclk), .o_sdata(o_sdata), .o_load_strobe(o_load_strobe), .o_marker(o_marker)
  );
  pls_synth_model syn (.i_sclk(o_sclk), .i_sdata(o_sdata), .i_load_strobe(o_load_strobe));

  // ==========================================================
  // clocks: link clock phase offset so edges never line up
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  initial begin
    i_link_clk = 1'b0;
    #17;
    forever #62.5 i_link_clk = ~i_link_clk;
  end

  // ==========================================================
  // monitors: marker framing, lamp run length, timeout
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    mk_q <= o_marker;
    if (i_resetn && o_load_strobe === 1'b0 && o_marker !== 1'b0) n_r1 <= n_r1 + 1;
    if (mk_q === 1'b1 && o_marker === 1'b0) n_fall <= n_fall + 1;
    if (o_marker === 1'b0) begin
      low_run <= low_run + 1;
    end else begin
      if (low_run != 0) last_low <= low_run;
      low_run <= 0;
    end
    if (cyc == LIMIT) begin
      n_errors++;
      $display("ERROR timeout expected halt seen none");
      end_sim;
    end
  end

  // ==========================================================
  // tasks: register access, reset, checks, verdict
  task automatic end_sim;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // one idle cycle after each strobe keeps a driver from doubling up
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask

  task automatic rd(input logic [7:0] a);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 rd_q = o_rdata;
    @(posedge i_clk);
  endtask

  // link side needs its own edges before release
  task automatic do_reset;
    i_resetn <= 1'b0;
    repeat (8) @(posedge i_clk);
    repeat (3) @(posedge i_link_clk);
    @(posedge i_clk);
    i_resetn <= 1'b1;
    @(posedge i_clk);
  endtask

  task automatic wait_halt;
    int n;
    rd_q = '0;
    for (n = 0; n < 4000 && rd_q[ST_HALT_BIT] !== 1'b1; n++) rd(ADDR_STATUS);
    `CHK("halted", 1'b1, rd_q[ST_HALT_BIT])
  endtask

  // expected word: table bytes in pointer order, padding forced to zero
  task automatic chk_pass(input int b0, input int ns, input int nb, input int p0);
    logic [31:0] ex;
    int s, b;
    for (s = 0; s < ns; s++) begin
      ex = '0;
      for (b = 0; b < nb; b++) ex = {ex[23:0], tbl[p0 + s * nb + b]};
      ex = ex & ((32'h1 << PAYLOAD_BITS) - 32'h1);
      `CHK("stream word", ex, syn.words[b0 + s])
      `CHK("stream bits", 32'(nb * 8), syn.nbits[b0 + s])
    end
  endtask

  // ==========================================================
  // main sequence
  initial begin
    i_resetn = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h00;
    i_wdata = 32'h0;
    i_diagnostic_select = 1'b1;
    for (i = 0; i < 16; i++) tbl[i] = 8'hff - 8'(i * 17);
    do_reset;
    rd(ADDR_STREAMS);
    `CHK("streams reset", 32'(STREAMS_DEF), rd_q)
    rd(ADDR_BYTES);
    `CHK("bytes reset", 32'(BYTES_DEF), rd_q)
    rd(8'h20);
    `CHK("unmapped read", 32'h0, rd_q)
    wr(ADDR_TIDX, 32'h0);
    for (i = 0; i < 16; i++) wr(ADDR_TDATA, {24'h0, tbl[i]});
    wr(ADDR_TIDX, 32'h0);
    rd(ADDR_TDATA);
    `CHK("table read", {24'h0, tbl[0]}, rd_q)
    // normal load: two streams, lamp, halt
    f0 = n_fall;
    wr(ADDR_CTRL, 32'h1);
    wait_halt;
    `CHK("streams sent", 2, syn.words.size())
    chk_pass(0, 2, 3, 0);
    `CHK("marker falls", 2, n_fall - f0)
    `CHK("lamp hold", 1'b1, last_low >= LAMP - 1 && last_low <= LAMP + 2)
    `CHK("marker after halt", 1'b1, o_marker)
    pins = {o_marker, o_load_strobe, o_sclk, o_sdata};
    wr(ADDR_CTRL, 32'h1);
    repeat (300) @(posedge i_clk);
    `CHK("pins held in halt", pins, {o_marker, o_load_strobe, o_sclk, o_sdata})
    `CHK("no restart after halt", 2, syn.words.size())
    // diagnostic repeat: four streams, select low for two passes
    do_reset;
    `CHK("idle pins", 3'b110, {o_marker, o_load_strobe, o_sclk})
    wr(ADDR_STREAMS, 32'h4);
    i_diagnostic_select <= 1'b0;
    base = syn.words.size();
    f0 = n_fall;
    wr(ADDR_CTRL, 32'h1);
    for (k = 0; k < 8000 && syn.words.size() < base + 8; k++) @(posedge i_clk);
    i_diagnostic_select <= 1'b1;
    wait_halt;
    np = (syn.words.size() - base) / 4;
    `CHK("whole passes", 0, (syn.words.size() - base) % 4)
    `CHK("repeated passes", 1'b1, np >= 2)
    for (k = 0; k < np; k++) chk_pass(base + 4 * k, 4, 3, 0);
    `CHK("falls per pass", np + 1, n_fall - f0)
    // four-byte stream: a whole leading byte of padding
    do_reset;
    wr(ADDR_BYTES, 32'h4);
    wr(ADDR_STREAMS, 32'h1);
    base = syn.words.size();
    wr(ADDR_CTRL, 32'h1);
    wait_halt;
    `CHK("long stream count", base + 1, syn.words.size())
    chk_pass(base, 1, 4, 0);
    `CHK("marker during strobe", 0, n_r1)
    `CHK("stray clocks", 0, syn.n_stray)
    end_sim;
  end
endmodule
